// ---- hw/isf_flags.sv ----
// Interrupt flags for slave write requests and master transaction done, with clock stretch.
// Assumes the I2C engine pulses slvAddrWrite and mstDoneStop, and samples sclHoldLow.
//
// Overview of operation
// [R1] Raise the slave-write flag, bit 18 of raw status, on slave write addressing.
// [R2] Slave-write flag is read-only, resets to zero, reads one while pending.
// [R3] Writing one to clear-register bit 18 clears the slave-write flag.
// [R4] Software may prepare the DMA descriptor when the slave-write flag rises.
// [R5] Set master-done flag when an own master transfer ends with stop.
// [R6] Software reads status, drains receive data, then clears master-done.
// [R7] Software issues no new master command before master-done is cleared.
// [R8] While master-done is set, hold SCL low and defer slave flags; the code holds SCL low only after a slave write arrives during master-done.
// [R9] Writing one to clear-register bit 19 clears master-done.
// [R10] Master-done sits at bit 19, read-only, resets zero, one when awaiting acknowledge.
// [R11] Flags stay set until cleared; a set in the clearing cycle wins.
`timescale 1ns/1ns
`default_nettype none
module isf_flags (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        slvAddrWrite,
    input  wire logic        mstDoneStop,
    output logic             sclHoldLow,
    output logic             slvWriteDeliver,
    output logic             irq
);
    logic        slvFlag_r;
    logic        mstFlag_r;
    logic        slvPending_r;
    logic [31:0] mask_r;
    logic        ctrlEnable_r;
    logic        wrPend_r;
    logic [7:0]  addr_r;
    logic        wrClear;
    logic        slvSet;
    logic [31:0] rawStatus;

    function automatic logic hitReg(input logic [7:0] a, input logic [7:0] offs);
        hitReg = (a == offs);
    endfunction

    // Address phase captured; slave always answers with zero wait states
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wrPend_r <= 1'b0;
            addr_r   <= 8'h00;
        end else if (hready) begin
            wrPend_r <= hsel && hwrite && htrans[1] && (hsize == isf_pkg::HSIZE_WORD);
            addr_r   <= haddr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wrClear   = wrPend_r && hitReg(addr_r, isf_pkg::CLEAR_OFFS);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mask_r       <= isf_pkg::RESET_VALUE;
            ctrlEnable_r <= 1'b0;
        end else begin
            if (wrPend_r && hitReg(addr_r, isf_pkg::MASK_OFFS))
                mask_r <= hwdata & isf_pkg::FLAG_MASK;
            if (wrPend_r && hitReg(addr_r, isf_pkg::CTRL_OFFS))
                ctrlEnable_r <= hwdata[isf_pkg::CTRL_SLV_ENABLE_BIT];
        end
    end

    // A slave request arriving while master-done is set waits here with SCL held
    always_ff @(posedge mclk) begin
        if (sys_rst)
            slvPending_r <= 1'b0;
        else if (slvAddrWrite && mstFlag_r)
            slvPending_r <= 1'b1; // [R8]
        else if (!mstFlag_r)
            slvPending_r <= 1'b0;
    end

    assign slvSet = (slvAddrWrite || slvPending_r) && !mstFlag_r; // [R8]

    always_ff @(posedge mclk) begin
        if (sys_rst)
            slvFlag_r <= 1'b0; // [R2]
        else if (slvSet)
            slvFlag_r <= 1'b1; // [R1] [R11]
        else if (wrClear && hwdata[isf_pkg::SLV_WR_BIT])
            slvFlag_r <= 1'b0; // [R3]
    end

    always_ff @(posedge mclk) begin
        if (sys_rst)
            mstFlag_r <= 1'b0; // [R10]
        else if (mstDoneStop)
            mstFlag_r <= 1'b1; // [R5] [R11]
        else if (wrClear && hwdata[isf_pkg::MST_DONE_BIT])
            mstFlag_r <= 1'b0; // [R9]
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclHoldLow      <= 1'b0;
            slvWriteDeliver <= 1'b0;
            irq             <= 1'b0;
        end else begin
            sclHoldLow      <= mstFlag_r && (slvPending_r || slvAddrWrite); // [R8]
            slvWriteDeliver <= slvSet && ctrlEnable_r;
            irq             <= |(rawStatus & mask_r);
        end
    end

    always_comb begin
        rawStatus = isf_pkg::RESET_VALUE;
        rawStatus[isf_pkg::SLV_WR_BIT]   = slvFlag_r;  // [R1]
        rawStatus[isf_pkg::MST_DONE_BIT] = mstFlag_r;  // [R10]
    end

    always_ff @(posedge mclk) begin
        if (sys_rst)
            hrdata <= isf_pkg::RESET_VALUE;
        else if (hready && hsel && !hwrite && htrans[1]) begin
            if (hitReg(haddr, isf_pkg::RAW_STATUS_OFFS))
                hrdata <= rawStatus;
            else if (hitReg(haddr, isf_pkg::MASK_OFFS))
                hrdata <= mask_r;
            else if (hitReg(haddr, isf_pkg::MASKED_OFFS))
                hrdata <= rawStatus & mask_r;
            else if (hitReg(haddr, isf_pkg::CTRL_OFFS))
                hrdata <= {31'h00000000, ctrlEnable_r};
            else
                hrdata <= isf_pkg::RESET_VALUE;
        end
    end

    mst_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        mstDoneStop |=> mstFlag_r) else $error("master-done not set"); // [R5]
    mst_clr_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (wrClear && hwdata[isf_pkg::MST_DONE_BIT] && !mstDoneStop) |=> !mstFlag_r)
        else $error("master-done not cleared"); // [R9]
    slv_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (slvAddrWrite && !mstFlag_r) |=> slvFlag_r) else $error("slave flag missed"); // [R1]
    slv_clr_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (wrClear && hwdata[isf_pkg::SLV_WR_BIT] && !slvSet) |=> !slvFlag_r)
        else $error("slave flag not cleared"); // [R3]
    slv_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mstFlag_r && !slvFlag_r && !slvSet && !wrClear) |=> !slvFlag_r)
        else $error("slave flag rose during master-done"); // [R8]
    scl_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (slvAddrWrite && mstFlag_r) |=> sclHoldLow) else $error("SCL not held"); // [R8]
    sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (mstFlag_r && !wrClear) |=> mstFlag_r) else $error("master-done dropped"); // [R11]
    raw_map_a: assert property (@(posedge mclk) disable iff (sys_rst)
        rawStatus == {12'h000, mstFlag_r, slvFlag_r, 18'h00000})
        else $error("raw status layout wrong"); // [R10]

    // A slave write that arrives while master-done waits for software
    sequence slvDeferred;
        slvAddrWrite && mstFlag_r;
    endsequence

    // Software acknowledges master-done with no fresh done pulse racing it
    sequence mstAck;
        wrClear && hwdata[isf_pkg::MST_DONE_BIT] && !mstDoneStop;
    endsequence

    // Done flag drops first, the held slave flag follows one cycle later
    sequence slvRelease;
        !mstFlag_r ##1 slvFlag_r;
    endsequence

    slv_release_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
        (slvPending_r ##0 mstAck) |=> slvRelease)
        else $error("held slave flag not released");

    scl_keep_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
        (slvDeferred ##1 (mstFlag_r && !mstAck)) |=> sclHoldLow)
        else $error("SCL released too early");

    // Stretching must end one cycle after the done flag drops, or the bus would stall
    scl_free_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R8]
        !mstFlag_r |=> !sclHoldLow)
        else $error("SCL held without master-done");

    slv_keep_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R11]
        (slvFlag_r && !(wrClear && hwdata[isf_pkg::SLV_WR_BIT])) |=> slvFlag_r)
        else $error("slave flag dropped");

    raw_read_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R2]
        (hready && hsel && !hwrite && htrans[1] && hitReg(haddr, isf_pkg::RAW_STATUS_OFFS))
        |=> (hrdata == $past(rawStatus)))
        else $error("raw status read wrong");

    dlv_gate_a: assert property (@(posedge mclk) disable iff (sys_rst) // [R1]
        slvWriteDeliver |-> $past(ctrlEnable_r))
        else $error("slave write delivered while disabled");

    irq_on_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (|(rawStatus & mask_r)) |=> irq)
        else $error("interrupt missing");

    irq_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !(|(rawStatus & mask_r)) |=> !irq)
        else $error("interrupt without cause");

    // Zero wait states and OKAY only; a master may rely on it
    bus_okay_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hreadyout && !hresp)
        else $error("bus response not okay");
endmodule
`default_nettype wire

// ---- hw/isf_pkg.sv ----
// Package for the slave-write / master-done interrupt flag block.
// Assumes a single 10 MHz clock domain and an AHB-Lite register port.
package isf_pkg;
    localparam logic [7:0] RAW_STATUS_OFFS = 8'h00;
    localparam logic [7:0] MASK_OFFS       = 8'h04;
    localparam logic [7:0] CLEAR_OFFS      = 8'h08;
    localparam logic [7:0] MASKED_OFFS     = 8'h0C;
    localparam logic [7:0] CTRL_OFFS       = 8'h10;
    localparam int SLV_WR_BIT  = 18;
    localparam int MST_DONE_BIT = 19;
    localparam logic [31:0] FLAG_MASK = 32'h000C0000;
    localparam logic [31:0] RESET_VALUE = 32'h00000000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam int CTRL_SLV_ENABLE_BIT = 0;
endpackage

// ---- bench/isf_engine_model.sv ----
// I2C engine stand-in: makes one-cycle event pulses towards the flag block.
// Assumes tasks are called just after a rising edge of mclk.
`timescale 1ns/1ns
`default_nettype none
module isf_engine_model (
    input  wire logic mclk,
    output logic      slvAddrWrite,
    output logic      mstDoneStop
);
    initial begin
        slvAddrWrite = 1'b0;
        mstDoneStop  = 1'b0;
    end
    // Own address seen with write
    task automatic slaveAddr();
        slvAddrWrite <= 1'b1;
        @(posedge mclk);
        slvAddrWrite <= 1'b0;
    endtask
    // Own master transfer closed by a stop
    task automatic masterDone();
        mstDoneStop <= 1'b1;
        @(posedge mclk);
        mstDoneStop <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Testbench for isf_flags over AHB-Lite, with the engine model.
// Assumes a 10 MHz clock; hreadyout is fed back as hready.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        mclk, sysRst, hsel, hwrite, hreadyout, hresp, irq;
    logic        slvAddrWrite, mstDoneStop, sclHoldLow, slvWriteDeliver;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    int          nMismatch, totalChecks, cyc, nDeliver;
    isf_flags u_isf_flags (.mclk, .sys_rst(sysRst), .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .slvAddrWrite,
        .mstDoneStop, .sclHoldLow, .slvWriteDeliver, .irq);
    isf_engine_model u_isf_engine_model (.mclk, .slvAddrWrite, .mstDoneStop);
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    task automatic closeOut();
        $display("Checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; hwrite <= w;
        htrans <= isf_pkg::HTRANS_NONSEQ; hsize <= isf_pkg::HSIZE_WORD;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Delivery is a one-cycle pulse, so it is counted rather than peeked at
    always @(posedge mclk) if (slvWriteDeliver === 1'b1) nDeliver++;
    always @(posedge mclk) if (++cyc == 3000) begin
        nMismatch++;
        closeOut();
    end
    initial begin
        sysRst = 1; hsel = 0; haddr = 8'h00; htrans = 2'h0; hwrite = 0;
        hsize = 3'h0; hwdata = 32'h00000000;
        repeat (6) @(posedge mclk);
        sysRst <= 1'b0;
        @(posedge mclk);
        bus(0, isf_pkg::RAW_STATUS_OFFS, 0); chk(rd, 32'h00000000);
        bus(1, isf_pkg::MASK_OFFS, isf_pkg::FLAG_MASK);
        bus(0, isf_pkg::MASK_OFFS, 0); chk(rd, 32'h000C0000);
        bus(1, isf_pkg::CTRL_OFFS, 32'h00000001);
        bus(0, isf_pkg::CTRL_OFFS, 0); chk(rd, 32'h00000001);
        u_isf_engine_model.slaveAddr(); @(posedge mclk);
        bus(0, isf_pkg::RAW_STATUS_OFFS, 0); chk(rd, 32'h00040000);
        bus(0, isf_pkg::MASKED_OFFS, 0); chk(rd, 32'h00040000);
        chk({31'h0, hresp}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        bus(1, isf_pkg::RAW_STATUS_OFFS, 32'hFFFFFFFF);
        bus(1, isf_pkg::CLEAR_OFFS, 32'h00080000);
        bus(0, isf_pkg::RAW_STATUS_OFFS, 0); chk(rd, 32'h00040000);
        bus(1, isf_pkg::CLEAR_OFFS, 32'h00040000);
        bus(0, isf_pkg::RAW_STATUS_OFFS, 0); chk(rd, 32'h00000000);
        chk({31'h0, irq}, 32'h0);
        u_isf_engine_model.masterDone(); @(posedge mclk);
        bus(0, isf_pkg::RAW_STATUS_OFFS, 0); chk(rd, 32'h00080000);
        u_isf_engine_model.slaveAddr(); repeat (2) @(posedge mclk);
        chk({31'h0, sclHoldLow}, 32'h1);
        bus(0, isf_pkg::RAW_STATUS_OFFS, 0); chk(rd, 32'h00080000);
        // Clear lands on the edge that samples a fresh done pulse
        fork
            bus(1, isf_pkg::CLEAR_OFFS, 32'h00080000);
            begin @(posedge mclk); u_isf_engine_model.masterDone(); end
        join
        bus(0, isf_pkg::RAW_STATUS_OFFS, 0); chk(rd, 32'h00080000);
        bus(1, isf_pkg::CLEAR_OFFS, 32'h00080000); repeat (2) @(posedge mclk);
        bus(0, isf_pkg::RAW_STATUS_OFFS, 0); chk(rd, 32'h00040000);
        chk({31'h0, sclHoldLow}, 32'h0);
        chk(nDeliver, 32'h2);
        closeOut();
    end
endmodule
`default_nettype wire
